//--- logic/acp_map.vh
// Address map, field positions and timing constants of the CPU port
`ifndef ACP_MAP_VH
`define ACP_MAP_VH

`define ACP_ADDR_W 11
`define ACP_DATA_W 32
`define ACP_CFG_ADDR 11'h508
`define ACP_CFG_RESET 32'h00000000
`define ACP_CFG_ENDIAN_BIT 0
`define ACP_ZERO_WORD 32'h00000000
`define ACP_CORE_MHZ 125
`define ACP_ACK_LAT 2'h1

`endif

//--- logic/acp_sync2.v
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module acp_sync2 #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b1}}
) (
   // Clock and reset
   input wire clk_i,
   input wire arst_n_i,
   // Levels
   input wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] meta;
   reg [W-1:0] stable;

   // First stage feeds only the second
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta <= INIT;
         stable <= INIT;
      end else begin
         meta <= d_i;
         stable <= meta;
      end
   end

   assign q_o = stable;
endmodule

//--- logic/acp_port.v
// Asynchronous 32-bit CPU register port working in the core clock domain
// Functional notes
// - Eleven-bit address selects register; host holds it steady all cycle.
// - Only whole 32-bit words cross the two-way data bus.
// - Strobes are ignored unless chip select is low.
// - Write strobe fall takes the address, its rise takes the data.
// - Read strobe fall takes the address of the returned register.
// - Active-low ready marks each finished cycle; pulled up when undriven.
// - Chip select stays low from address until ready returns.
// - Read: address, strobe, device latches, drives data, then ready.
// - Write: strobe, address latched, data, strobe release, store, ready.
// - All register work runs on the core clock; pins have no clock.
// - A byte-order bit in the config register swaps data lanes.
`timescale 1ns/1ns
`include "acp_map.vh"
module acp_port #(
   parameter AW = `ACP_ADDR_W,
   parameter DW = `ACP_DATA_W
) (
   // Core clock and reset
   input wire CLK_SYS_I,
   input wire ARST_N_I,
   // Host pins
   input wire [AW-1:0] HOST_ADDR_I,
   input wire HOST_SELECT_N_I,
   input wire HOST_WRITE_N_I,
   input wire HOST_READ_N_I,
   input wire [DW-1:0] HOST_DQ_I,
   output wire [DW-1:0] HOST_DQ_O,
   output wire HOST_DQ_OE_N_O,
   output wire CYCLE_DONE_N_O,
   output wire CYCLE_DONE_OE_N_O,
   // Core register access
   output reg [AW-1:0] REG_ADDR_O,
   output reg [DW-1:0] REG_WDATA_O,
   output reg REG_WR_O,
   output reg REG_RD_O,
   input wire [DW-1:0] REG_RDATA_I,
   input wire REG_ACK_I,
   // Byte order currently selected
   output wire BIG_ENDIAN_O
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RD_WAIT = 3'h1;
   localparam [2:0] ST_RD_DONE = 3'h2;
   localparam [2:0] ST_WR_HOLD = 3'h3;
   localparam [2:0] ST_WR_WAIT = 3'h4;
   localparam [2:0] ST_WR_DONE = 3'h5;
   localparam [2:0] ST_REARM = 3'h6;

   // Synchronised control, address and data pins
   wire [2:0] ctl_s;
   wire [AW-1:0] addr_s;
   wire [DW-1:0] dq_s;
   wire sel;
   wire wr;
   wire rd;
   wire strobes_idle;

   // Sequencer state
   reg [2:0] state;
   reg [2:0] next_state;

   // Local config word and the word returned to the host
   reg [DW-1:0] cfg;
   reg [DW-1:0] rd_hold;

   // Pin drive flags and the hit on the local register
   reg done;
   reg drive;
   reg local_hit;

   // Chip select passes two flip-flops before the FSM sees it
   acp_sync2 #(.W(1), .INIT(1'h1)) u_sel_sync (
      .clk_i(CLK_SYS_I),
      .arst_n_i(ARST_N_I),
      .d_i(HOST_SELECT_N_I),
      .q_o(ctl_s[2])
   );

   // Write strobe, idle high out of reset so no false strobe follows
   acp_sync2 #(.W(1), .INIT(1'h1)) u_wr_sync (
      .clk_i(CLK_SYS_I),
      .arst_n_i(ARST_N_I),
      .d_i(HOST_WRITE_N_I),
      .q_o(ctl_s[1])
   );

   // Read strobe, idle high out of reset as well
   acp_sync2 #(.W(1), .INIT(1'h1)) u_rd_sync (
      .clk_i(CLK_SYS_I),
      .arst_n_i(ARST_N_I),
      .d_i(HOST_READ_N_I),
      .q_o(ctl_s[0])
   );

   // Address is stable across the cycle, sampled the same way
   acp_sync2 #(.W(AW), .INIT({AW{1'b0}})) u_addr_sync (
      .clk_i(CLK_SYS_I),
      .arst_n_i(ARST_N_I),
      .d_i(HOST_ADDR_I),
      .q_o(addr_s)
   );

   // Write data is stable across the cycle, sampled the same way
   acp_sync2 #(.W(DW), .INIT({DW{1'b0}})) u_dq_sync (
      .clk_i(CLK_SYS_I),
      .arst_n_i(ARST_N_I),
      .d_i(HOST_DQ_I),
      .q_o(dq_s)
   );

   // Strobes only count while the chip is selected
   assign sel = ~ctl_s[2];
   assign wr = sel & ~ctl_s[1];
   assign rd = sel & ~ctl_s[0];
   // Both strobes back high or select released, the only way to rearm
   assign strobes_idle = !wr && !rd;

   // Lane swap for big-endian hosts
   function [DW-1:0] swap;
      input [DW-1:0] v;
      integer k;
      begin
         for (k = 0; k < DW / 8; k = k + 1) begin
            swap[8*k +: 8] = v[DW-8-8*k +: 8];
         end
      end
   endfunction

   assign BIG_ENDIAN_O = cfg[`ACP_CFG_ENDIAN_BIT];

   // Next state of the access sequencer
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (rd && !wr) begin
               next_state = ST_RD_WAIT;
            end else if (wr && !rd) begin
               next_state = ST_WR_HOLD;
            end
         end
         ST_RD_WAIT: begin
            if (!rd) begin
               next_state = ST_REARM;
            end else if (local_hit || REG_ACK_I) begin
               next_state = ST_RD_DONE;
            end
         end
         ST_RD_DONE: begin
            if (!rd) begin
               next_state = ST_REARM;
            end
         end
         ST_WR_HOLD: begin
            if (!sel) begin
               next_state = ST_REARM;
            end else if (!wr) begin
               next_state = ST_WR_WAIT;
            end
         end
         ST_WR_WAIT: begin
            if (local_hit || REG_ACK_I) begin
               next_state = ST_WR_DONE;
            end
         end
         ST_WR_DONE: begin
            // Select kept low: a new strobe returns to idle without the rearm wait
            if (!sel) begin
               next_state = ST_REARM;
            end else if (wr || rd) begin
               next_state = ST_IDLE;
            end
         end

         ST_REARM: begin
            if (strobes_idle) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Sequencer steps that load the latches below
   wire start_cycle;
   wire start_rd;
   wire take_wdata;
   wire take_rdata;
   wire ready_on;

   // Decodes of the transitions that matter to the datapath
   assign start_cycle = (state == ST_IDLE) && (next_state != ST_IDLE);
   assign start_rd = start_cycle && (next_state == ST_RD_WAIT);
   assign take_wdata = (state == ST_WR_HOLD) && (next_state == ST_WR_WAIT);
   assign take_rdata = (state == ST_RD_WAIT) && (next_state == ST_RD_DONE);

   // Sequencer state, stepped by the core clock only
   always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Address latch at the strobe fall, with the local hit flag
   always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         REG_ADDR_O <= {AW{1'b0}};
         local_hit <= 1'b0;
      end else if (start_cycle) begin
         REG_ADDR_O <= addr_s;
         local_hit <= (addr_s == `ACP_CFG_ADDR);
      end
   end

   // One-cycle core read; the local config word needs none
   always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         REG_RD_O <= 1'b0;
      end else begin
         REG_RD_O <= start_rd && (addr_s != `ACP_CFG_ADDR);
      end
   end

   // One-cycle core write once the host has released its strobe
   always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         REG_WR_O <= 1'b0;
      end else begin
         REG_WR_O <= take_wdata && !local_hit;
      end
   end

   // Write data taken at strobe release, swapped to core order when the byte-order bit is set
   always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         REG_WDATA_O <= `ACP_ZERO_WORD;
      end else if (take_wdata && cfg[`ACP_CFG_ENDIAN_BIT]) begin
         REG_WDATA_O <= swap(dq_s);
      end else if (take_wdata) begin
         REG_WDATA_O <= dq_s;
      end
   end

   // Config register held locally; its low bit picks the byte order
   always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         cfg <= `ACP_CFG_RESET;
      end else if (take_wdata && local_hit) begin
         cfg <= dq_s;
      end
   end

   // Read word held for the pins; the config word goes out unswapped
   always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rd_hold <= `ACP_ZERO_WORD;
      end else if (take_rdata && local_hit) begin
         rd_hold <= cfg;
      end else if (take_rdata && cfg[`ACP_CFG_ENDIAN_BIT]) begin
         rd_hold <= swap(REG_RDATA_I);
      end else if (take_rdata) begin
         rd_hold <= REG_RDATA_I;
      end
   end

   // Data goes on the bus a cycle before ready is pulled low
   always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         drive <= 1'b0;
      end else begin
         drive <= (next_state == ST_RD_DONE);
      end
   end

   // Finished flag behind ready, for reads one cycle after the data
   always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         done <= 1'b0;
      end else begin
         done <= (next_state == ST_RD_DONE && state == ST_RD_DONE) ||
            (next_state == ST_WR_DONE);
      end
   end

   // Ready only while the finished cycle is still selected
   assign ready_on = done & sel &
      (state == ST_RD_DONE || state == ST_WR_DONE);

   // Pin drivers; enables low while driving, released otherwise
   assign HOST_DQ_O = rd_hold;
   assign HOST_DQ_OE_N_O = ~(drive & rd);
   assign CYCLE_DONE_N_O = 1'b0;
   assign CYCLE_DONE_OE_N_O = ~ready_on;
endmodule

//--- verif/acp_props.sv
// Port timing properties
`timescale 1ns/1ns
module acp_props #(parameter AW = 11) (
   // Clock and reset
   input wire CLK_SYS_I,
   input wire ARST_N_I,
   // Host pins
   input wire [AW-1:0] HOST_ADDR_I,
   input wire HOST_SELECT_N_I,
   input wire HOST_WRITE_N_I,
   input wire HOST_READ_N_I,
   input wire HOST_DQ_OE_N_O,
   input wire CYCLE_DONE_OE_N_O,
   // Core side
   input wire [AW-1:0] REG_ADDR_O,
   input wire REG_WR_O,
   input wire REG_RD_O,
   input wire REG_ACK_I
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!ARST_N_I);
   // Core access and its acknowledge
   sequence s_rack; REG_RD_O ##[1:4] REG_ACK_I; endsequence
   sequence s_wack; REG_WR_O ##[1:4] REG_ACK_I; endsequence
   property p_rdy_rd; s_rack |-> ##[1:3] !CYCLE_DONE_OE_N_O; endproperty
   a_rdy_rd: assert property (p_rdy_rd) else $error("rd rdy");
   property p_rdy_wr; s_wack |-> ##[1:2] !CYCLE_DONE_OE_N_O; endproperty
   a_rdy_wr: assert property (p_rdy_wr) else $error("wr rdy");
   property p_sel; $fell(CYCLE_DONE_OE_N_O) |-> !HOST_SELECT_N_I; endproperty
   a_sel: assert property (p_sel) else $error("rdy unsel");
   property p_nosel; HOST_SELECT_N_I [*4] |-> !REG_RD_O && !REG_WR_O;
   endproperty
   a_nosel: assert property (p_nosel) else $error("unsel acc");
   property p_rel; HOST_SELECT_N_I [*4] |-> CYCLE_DONE_OE_N_O &&
      HOST_DQ_OE_N_O; endproperty
   a_rel: assert property (p_rel) else $error("no release");
   property p_ord; $fell(HOST_DQ_OE_N_O) |-> CYCLE_DONE_OE_N_O; endproperty
   a_ord: assert property (p_ord) else $error("rdy early");
   property p_rd; REG_RD_O |-> REG_ADDR_O == HOST_ADDR_I && !HOST_READ_N_I;
   endproperty
   a_rd: assert property (p_rd) else $error("rd addr");
   property p_wr; REG_WR_O |-> REG_ADDR_O == HOST_ADDR_I && HOST_WRITE_N_I;
   endproperty
   a_wr: assert property (p_wr) else $error("wr addr");
endmodule
bind acp_port acp_props #(.AW(AW)) u_props (.*);

//--- verif/acp_host.sv
// Host model driving the port pins
`timescale 1ns/1ns
module acp_host (
   // Clock
   input wire clk_i,
   // Device pins
   input wire [31:0] dq_i,
   input wire dq_oe_n_i,
   input wire done_n_i,
   input wire done_oe_n_i,
   // Host pins
   output reg [10:0] addr_o = 0,
   output reg sel_n_o = 1,
   output reg wr_n_o = 1,
   output reg rd_n_o = 1,
   output reg [31:0] wd_o = 0,
   output wire [31:0] bus_o
);
   integer n;
   wire rdy = done_oe_n_i | done_n_i;
   // Resolved data wire
   assign bus_o = dq_oe_n_i ? wd_o : dq_i;
   // Bounded wait for ready
   task wt;
      begin
         for (n = 0; n < 60 && rdy; n++) @(posedge clk_i);
         if (rdy) begin
            acp_port_bench.fail_count++;
            acp_port_bench.end_of_test;
         end
      end
   endtask
   // Write; s high leaves the port unselected
   task wr(input [10:0] a, input [31:0] d, input k, input s);
      begin
         @(posedge clk_i);
         sel_n_o <= s;
         addr_o <= a;
         wd_o <= d;
         wr_n_o <= 1'b0;
         repeat (4) @(posedge clk_i);
         wr_n_o <= 1'b1;
         if (!s) wt;
         sel_n_o <= k;
         repeat (4) @(posedge clk_i);
      end
   endtask
   // Read returning the word seen with ready
   task rd(input [10:0] a, output [31:0] q);
      begin
         @(posedge clk_i);
         sel_n_o <= 1'b0;
         addr_o <= a;
         wd_o <= ~wd_o;
         rd_n_o <= 1'b0;
         repeat (4) @(posedge clk_i);
         wt;
         q = bus_o;
         rd_n_o <= 1'b1;
         sel_n_o <= 1'b1;
         repeat (4) @(posedge clk_i);
      end
   endtask
endmodule

//--- verif/acp_port_bench.sv
// Self-checking bench for the CPU port
`timescale 1ns/1ns
module acp_port_bench;
   reg clk = 0;
   reg arst_n = 0;
   reg ack = 0, slow = 0, p1 = 0;
   reg [31:0] rdat = 0, q;
   reg [31:0] mem [0:2047];
   integer fail_count = 0, checked = 0;
   wire [10:0] a, ra;
   wire sn, wn, rn, doe, dn, roe, big, rw, rr;
   wire [31:0] wd, bus, dq, rwd;
   // Clock
   initial forever #5 clk = ~clk;
   acp_host h (.clk_i(clk), .dq_i(dq), .dq_oe_n_i(doe), .done_n_i(dn),
      .done_oe_n_i(roe), .addr_o(a), .sel_n_o(sn), .wr_n_o(wn),
      .rd_n_o(rn), .wd_o(wd), .bus_o(bus));
   acp_port dut (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .HOST_ADDR_I(a),
      .HOST_SELECT_N_I(sn), .HOST_WRITE_N_I(wn), .HOST_READ_N_I(rn),
      .HOST_DQ_I(bus), .HOST_DQ_O(dq), .HOST_DQ_OE_N_O(doe),
      .CYCLE_DONE_N_O(dn), .CYCLE_DONE_OE_N_O(roe), .REG_ADDR_O(ra),
      .REG_WDATA_O(rwd), .REG_WR_O(rw), .REG_RD_O(rr),
      .REG_RDATA_I(rdat), .REG_ACK_I(ack), .BIG_ENDIAN_O(big));
   // Core bank acking one or two cycles later
   always @(posedge clk) begin
      p1 <= rw | rr;
      ack <= slow ? p1 : (rw | rr);
      if (rw) mem[ra] <= rwd;
      if (rr) rdat <= mem[ra];
   end
   // Compare
   task cmp(input string nm, input [31:0] e, input [31:0] g);
      begin
         checked++;
         if (g !== e) begin
            fail_count++;
            $display("mismatch %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // Verdict
   task end_of_test;
      begin
         $display("checked %0d fail_count %0d", checked, fail_count);
         if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // Tests
   initial begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      h.rd(11'h508, q);
      cmp("cfg", 32'h0, q);
      $display("test reset done");
      h.wr(11'h7FF, 32'hA5C31E0F, 1'b0, 1'b0);
      h.wr(11'h001, 32'h5A3CE1F0, 1'b1, 1'b0);
      cmp("m7ff", 32'hA5C31E0F, mem[11'h7FF]);
      cmp("m001", 32'h5A3CE1F0, mem[11'h001]);
      h.rd(11'h7FF, q);
      cmp("r7ff", 32'hA5C31E0F, q);
      $display("test access done");
      slow <= 1'b1;
      h.wr(11'h001, 32'h0, 1'b1, 1'b1);
      cmp("stray", 32'h5A3CE1F0, mem[11'h001]);
      h.wr(11'h508, 32'h1, 1'b1, 1'b0);
      cmp("big", 32'h1, {31'h0, big});
      h.wr(11'h002, 32'h12345678, 1'b1, 1'b0);
      cmp("swap", 32'h78563412, mem[11'h002]);
      h.rd(11'h002, q);
      cmp("rswap", 32'h12345678, q);
      h.rd(11'h508, q);
      cmp("cfg1", 32'h1, q);
      $display("test endian done");
      end_of_test;
   end
endmodule
